// ---- verilog/pecc_map.vh ----
// register offsets, field positions and reset values of the transceiver event block
// assumes byte offsets on the controller's i/o register space, 16-bit registers
`ifndef PECC_MAP_VH
`define PECC_MAP_VH

// ************************************************************
// register offsets
// ************************************************************
`define PECC_ADDR_W            8
`define PECC_OFF_IRQ_CONTROL   8'hC4
`define PECC_OFF_IRQ_STATUS    8'hC8
`define PECC_OFF_FALSE_CARRIER 8'hD0
`define PECC_OFF_RX_ERROR      8'hD4
`define PECC_OFF_CODING_CFG    8'hD8

// ************************************************************
// reset values
// ************************************************************
`define PECC_RST_IRQ_CONTROL   16'h0000
`define PECC_RST_IRQ_STATUS    16'h0000
`define PECC_RST_COUNT         8'h00
`define PECC_RST_CODING_CFG    16'h0100

// ************************************************************
// irq_control fields
// ************************************************************
`define PECC_CTL_TEST_IRQ      0
`define PECC_CTL_EVENT_EN      1

// ************************************************************
// irq_status_mask fields
// ************************************************************
`define PECC_STS_PENDING       15
`define PECC_STS_MASK_HI       14
`define PECC_STS_MASK_LO       9
`define PECC_MASK_LINK         14
`define PECC_MSK_JABBER        13
`define PECC_MSK_RFAULT        12
`define PECC_MSK_ANDONE        11
`define PECC_MSK_FC_HALF       10
`define PECC_MSK_RXE_HALF      9

// ************************************************************
// coding_layer_config fields
// ************************************************************
`define PECC_CFG_BLOCK_BYPASS  12
`define PECC_CFG_FREE_CLK      11
`define PECC_CFG_TRUE_QUIET    10
`define PECC_CFG_SD_FORCE      9
`define PECC_CFG_SD_ALGO       8
`define PECC_CFG_FORCE_100     5
`define PECC_CFG_NRZI_BYPASS   2
`define PECC_CFG_WMASK         16'h1F24

// ************************************************************
// counters
// ************************************************************
`define PECC_CNT_W             8
`define PECC_CNT_MAX           8'hFF
`define PECC_CNT_HALF_BIT      7

`endif

// ---- verilog/pecc_top.v ----
// transceiver event interrupt control, error counters and coding-layer configuration
// assumes event inputs come from logic on clk_i; register port is a single-cycle strobe port
// Functional notes
// RULE1: six event sources: link change, jabber, remote fault, autoneg done, false carrier half, rx error half.
// RULE2: with test_irq set, every register read raises a pending interrupt.
// RULE3: test interrupt ignores the event enable bit.
// RULE4: event_irq_enable bit 1 passes event interrupts when set, blocks when clear.
// RULE5: irq_control bits 15:2 ignore writes and read zero.
// RULE6: unmasked enabled event asserts the host transceiver event flag.
// RULE7: status bit 15 shows pending, cleared by the read returning it.
// RULE8: bit 14 masks link change, bit 13 masks jabber; zero lets through.
// RULE9: bit 12 masks remote fault, bit 11 masks autoneg done.
// RULE10: bit 10 masks false carrier half, bit 9 masks rx error half.
// RULE11: 8-bit false carrier counter counts each event; upper bits read zero.
// RULE12: false carrier counter saturates at FFh.
// RULE13: both counters reset zero, are writable, and clear on read.
// RULE14: rx error counter counts carrier events containing an invalid symbol.
// RULE15: rx error counter advances at most once per carrier event.
// RULE16: carrier events with collision do not advance the rx error counter.
// RULE17: rx error counter saturates at maximum and holds until cleared.
// RULE18: config bit 12 bypasses the 4B/5B coder.
// RULE19: config bit 11 makes the receive clock free-running.
// RULE20: bit 10 selects true quiet transmit; bit 9 forces signal detect.
// RULE21: bit 8 picks enhanced signal detect; config resets to 0100h.
// RULE22: bit 5 forces 100 Mb/s link ORed with controller input; bit 2 bypasses NRZI.
// RULE23: half-full event fires when a counter first reaches 80h.
`timescale 1ns/1ps
`include "pecc_map.vh"

module pecc_top (
	input  wire        clk_i,
	input  wire        rstn_i,
	input  wire [7:0]  reg_addr_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	input  wire [15:0] reg_wdata_i,
	output reg  [15:0] reg_rdata_o,
	output reg         reg_rvalid_o,
	input  wire        link_change_i,
	input  wire        jabber_i,
	input  wire        remote_fault_i,
	input  wire        autoneg_done_i,
	input  wire        false_carrier_i,
	input  wire        carrier_i,
	input  wire        symbol_error_i,
	input  wire        collision_i,
	input  wire        controller_force_fast_link_i,
	output reg         host_status_transceiver_event_o,
	output reg         block_code_bypass_o,
	output reg         receive_clock_free_o,
	output reg         true_quiet_enable_o,
	output reg         signal_detect_force_o,
	output reg         signal_detect_algorithm_o,
	output reg         force_fast_link_o,
	output reg         nrzi_bypass_o
);

	// ************************************************************
	// functions
	// ************************************************************
	// saturating counter update: write loads, read clears, event adds one
	function [7:0] pecc_count;
		input [7:0] cur;
		input       wr;
		input [7:0] wval;
		input       rd;
		input       inc;
		reg   [7:0] base;
		begin
			base = rd ? `PECC_RST_COUNT : cur;
			if (wr)
				pecc_count = wval;
			else if (inc && (base != `PECC_CNT_MAX))
				pecc_count = base + 8'h01;
			else
				pecc_count = base;
		end
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	reg        event_en_r;
	reg        test_irq_r;
	reg        pending_r;
	reg [5:0]  mask_r;
	reg [7:0]  fc_count_r;
	reg [7:0]  rxe_count_r;
	reg [15:0] cfg_r;
	reg        carrier_d_r;
	reg        err_seen_r;
	reg        coll_seen_r;

	wire       sel_ctl = (reg_addr_i == `PECC_OFF_IRQ_CONTROL);
	wire       sel_sts = (reg_addr_i == `PECC_OFF_IRQ_STATUS);
	wire       sel_fc  = (reg_addr_i == `PECC_OFF_FALSE_CARRIER);
	wire       sel_rxe = (reg_addr_i == `PECC_OFF_RX_ERROR);
	wire       sel_cfg = (reg_addr_i == `PECC_OFF_CODING_CFG);

	// rx error: judged at carrier end so a late collision still vetoes it
	wire       carrier_end = carrier_d_r & ~carrier_i;
	wire       rxe_inc     = carrier_end & err_seen_r & ~coll_seen_r;            // [RULE14] [RULE15] [RULE16]

	wire [7:0] fc_nxt  = pecc_count(fc_count_r, reg_wr_i & sel_fc, reg_wdata_i[7:0],
	                                reg_rd_i & sel_fc, false_carrier_i);        // [RULE11] [RULE12] [RULE13]
	wire [7:0] rxe_nxt = pecc_count(rxe_count_r, reg_wr_i & sel_rxe, reg_wdata_i[7:0],
	                                reg_rd_i & sel_rxe, rxe_inc);               // [RULE13] [RULE17]

	wire       fc_half  = fc_nxt[`PECC_CNT_HALF_BIT] & ~fc_count_r[`PECC_CNT_HALF_BIT];   // [RULE23]
	wire       rxe_half = rxe_nxt[`PECC_CNT_HALF_BIT] & ~rxe_count_r[`PECC_CNT_HALF_BIT]; // [RULE23]

	// mask_r[5:0] maps status bits 14:9
	wire [5:0] events = {link_change_i, jabber_i, remote_fault_i,
	                     autoneg_done_i, fc_half, rxe_half};                    // [RULE1]
	wire       event_hit = event_en_r & (|(events & ~mask_r));                  // [RULE4] [RULE6] [RULE8] [RULE9] [RULE10]
	wire       test_hit  = test_irq_r & reg_rd_i;                               // [RULE2] [RULE3]

	// ************************************************************
	// read mux
	// ************************************************************
	reg [15:0] rdata_nxt;
	always @* begin
		rdata_nxt = 16'h0000;
		case (1'b1)
			sel_ctl: rdata_nxt = {14'h0000, event_en_r, test_irq_r};           // [RULE5]
			sel_sts: rdata_nxt = {pending_r, mask_r, 9'h000};                   // [RULE7]
			sel_fc:  rdata_nxt = {8'h00, fc_count_r};                            // [RULE11]
			sel_rxe: rdata_nxt = {8'h00, rxe_count_r};
			sel_cfg: rdata_nxt = cfg_r;
			default: rdata_nxt = 16'h0000;
		endcase
	end

	// ************************************************************
	// registers
	// ************************************************************
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			event_en_r   <= 1'b0;
			test_irq_r   <= 1'b0;
			pending_r    <= 1'b0;
			mask_r       <= 6'h00;
			fc_count_r   <= `PECC_RST_COUNT;
			rxe_count_r  <= `PECC_RST_COUNT;
			cfg_r        <= `PECC_RST_CODING_CFG;                                 // [RULE21]
			carrier_d_r  <= 1'b0;
			err_seen_r   <= 1'b0;
			coll_seen_r  <= 1'b0;
			reg_rdata_o  <= 16'h0000;
			reg_rvalid_o <= 1'b0;
		end else begin
			if (reg_wr_i && sel_ctl) begin
				event_en_r <= reg_wdata_i[`PECC_CTL_EVENT_EN];                  // [RULE4]
				test_irq_r <= reg_wdata_i[`PECC_CTL_TEST_IRQ];
			end
			if (reg_wr_i && sel_sts)
				mask_r <= reg_wdata_i[`PECC_STS_MASK_HI:`PECC_STS_MASK_LO];
			if (reg_wr_i && sel_cfg)
				cfg_r <= reg_wdata_i & `PECC_CFG_WMASK;
			// a new interrupt in the clearing read's cycle survives the clear
			if (event_hit || test_hit)
				pending_r <= 1'b1;                                              // [RULE2] [RULE6]
			else if (reg_rd_i && sel_sts)
				pending_r <= 1'b0;                                              // [RULE7]
			fc_count_r  <= fc_nxt;
			rxe_count_r <= rxe_nxt;
			carrier_d_r <= carrier_i;
			if (carrier_i) begin
				err_seen_r  <= err_seen_r | symbol_error_i;
				coll_seen_r <= coll_seen_r | collision_i;
			end else begin
				err_seen_r  <= 1'b0;
				coll_seen_r <= 1'b0;
			end
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i)
				reg_rdata_o <= rdata_nxt;
		end
	end

	// ************************************************************
	// host event flag and configuration outputs
	// ************************************************************
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			host_status_transceiver_event_o <= 1'b0;
			block_code_bypass_o             <= 1'b0;
			receive_clock_free_o            <= 1'b0;
			true_quiet_enable_o             <= 1'b0;
			signal_detect_force_o           <= 1'b0;
			signal_detect_algorithm_o       <= 1'b1;
			force_fast_link_o               <= 1'b0;
			nrzi_bypass_o                   <= 1'b0;
		end else begin
			host_status_transceiver_event_o <= pending_r;                      // [RULE6]
			block_code_bypass_o             <= cfg_r[`PECC_CFG_BLOCK_BYPASS];  // [RULE18]
			receive_clock_free_o            <= cfg_r[`PECC_CFG_FREE_CLK];      // [RULE19]
			true_quiet_enable_o             <= cfg_r[`PECC_CFG_TRUE_QUIET];    // [RULE20]
			signal_detect_force_o           <= cfg_r[`PECC_CFG_SD_FORCE];      // [RULE20]
			signal_detect_algorithm_o       <= cfg_r[`PECC_CFG_SD_ALGO];       // [RULE21]
			force_fast_link_o               <= cfg_r[`PECC_CFG_FORCE_100] | controller_force_fast_link_i; // [RULE22]
			nrzi_bypass_o                   <= cfg_r[`PECC_CFG_NRZI_BYPASS];   // [RULE22]
		end
	end

endmodule // pecc_top

// ---- sim/pecc_properties.sv ----
// concurrent checks on the register port and pin outputs of pecc_top
// assumes a bind onto pecc_top: one clock, active-low asynchronous reset
`timescale 1ns/1ps
// ********************
// checker
// ********************
module pecc_props (
	input wire        clk_i,
	input wire        rstn_i,
	input wire [7:0]  reg_addr_i,
	input wire        reg_wr_i,
	input wire        reg_rd_i,
	input wire [15:0] reg_wdata_i,
	input wire [15:0] reg_rdata_o,
	input wire        reg_rvalid_o,
	input wire        false_carrier_i,
	input wire        controller_force_fast_link_i,
	input wire        host_status_transceiver_event_o,
	input wire        block_code_bypass_o,
	input wire        receive_clock_free_o,
	input wire        true_quiet_enable_o,
	input wire        signal_detect_force_o,
	input wire        signal_detect_algorithm_o,
	input wire        force_fast_link_o,
	input wire        nrzi_bypass_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// decodes kept as nets so that each property reads as one relation
	wire rd_sts = reg_rd_i && (reg_addr_i == 8'hC8);
	wire rd_fc  = reg_rd_i && (reg_addr_i == 8'hD0);
	wire wr_cfg = reg_wr_i && (reg_addr_i == 8'hD8);
	rd_valid_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read gave no valid");
	host_mirror_a: assert property (rd_sts |=> host_status_transceiver_event_o == reg_rdata_o[15])
		else $error("host event differs from pending");
	sts_low_a: assert property (rd_sts |=> reg_rdata_o[8:0] == 9'h000) else $error("status low bits set");
	ctl_upper_a: assert property (reg_rd_i && reg_addr_i == 8'hC4 |=> reg_rdata_o[15:2] == 14'h0000)
		else $error("control upper bits set");
	cnt_upper_a: assert property (reg_rd_i && reg_addr_i[7:4] == 4'hD && !reg_addr_i[3] |=>
		reg_rdata_o[15:8] == 8'h00) else $error("counter upper bits set");
	cor_clear_a: assert property (rd_fc && !false_carrier_i && !reg_wr_i
		##1 !false_carrier_i && !reg_wr_i ##1 rd_fc |=> reg_rdata_o == 16'h0000)
		else $error("counter kept value after read");
	cfg_copy_a: assert property (wr_cfg |-> ##2
		{block_code_bypass_o, receive_clock_free_o, true_quiet_enable_o, signal_detect_force_o} ==
		$past(reg_wdata_i[12:9], 2)) else $error("config pins wrong");
	sd_nrzi_a: assert property (wr_cfg |-> ##2
		{signal_detect_algorithm_o, nrzi_bypass_o} == {$past(reg_wdata_i[8], 2), $past(reg_wdata_i[2], 2)})
		else $error("detect pins wrong");
	force_or_a: assert property (controller_force_fast_link_i |=> force_fast_link_o)
		else $error("force link not passed");
endmodule // pecc_props
bind pecc_top pecc_props u_props (
	.clk_i                           (clk_i),
	.rstn_i                          (rstn_i),
	.reg_addr_i                      (reg_addr_i),
	.reg_wr_i                        (reg_wr_i),
	.reg_rd_i                        (reg_rd_i),
	.reg_wdata_i                     (reg_wdata_i),
	.reg_rdata_o                     (reg_rdata_o),
	.reg_rvalid_o                    (reg_rvalid_o),
	.false_carrier_i                 (false_carrier_i),
	.controller_force_fast_link_i    (controller_force_fast_link_i),
	.host_status_transceiver_event_o (host_status_transceiver_event_o),
	.block_code_bypass_o             (block_code_bypass_o),
	.receive_clock_free_o            (receive_clock_free_o),
	.true_quiet_enable_o             (true_quiet_enable_o),
	.signal_detect_force_o           (signal_detect_force_o),
	.signal_detect_algorithm_o       (signal_detect_algorithm_o),
	.force_fast_link_o               (force_fast_link_o),
	.nrzi_bypass_o                   (nrzi_bypass_o)
);

// ---- sim/pecc_tb_top.sv ----
// self-checking bench for pecc_top, driven through its strobe register port
// assumes the design's one-cycle read answer and event pulses on clk_i
`timescale 1ns/1ps
// ********************
// bench
// ********************
module pecc_tb_top;
	reg         clk_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	reg         link_change_i = 1'b0, jabber_i = 1'b0, remote_fault_i = 1'b0, autoneg_done_i = 1'b0;
	reg         false_carrier_i = 1'b0, carrier_i = 1'b0, symbol_error_i = 1'b0, collision_i = 1'b0;
	reg         controller_force_fast_link_i = 1'b0;
	reg  [7:0]  reg_addr_i = 8'h00;
	reg  [15:0] reg_wdata_i = 16'h0000;
	wire [15:0] reg_rdata_o;
	wire        reg_rvalid_o, host_status_transceiver_event_o, block_code_bypass_o, receive_clock_free_o;
	wire        true_quiet_enable_o, signal_detect_force_o, signal_detect_algorithm_o, force_fast_link_o, nrzi_bypass_o;
	wire [6:0]  cfg = {block_code_bypass_o, receive_clock_free_o, true_quiet_enable_o, signal_detect_force_o,
		signal_detect_algorithm_o, force_fast_link_o, nrzi_bypass_o};
	integer     miscompares = 0, checks = 0, i;
	always #50 clk_i = ~clk_i;
	pecc_top DUT (
		.clk_i                           (clk_i),
		.rstn_i                          (rstn_i),
		.reg_addr_i                      (reg_addr_i),
		.reg_wr_i                        (reg_wr_i),
		.reg_rd_i                        (reg_rd_i),
		.reg_wdata_i                     (reg_wdata_i),
		.reg_rdata_o                     (reg_rdata_o),
		.reg_rvalid_o                    (reg_rvalid_o),
		.link_change_i                   (link_change_i),
		.jabber_i                        (jabber_i),
		.remote_fault_i                  (remote_fault_i),
		.autoneg_done_i                  (autoneg_done_i),
		.false_carrier_i                 (false_carrier_i),
		.carrier_i                       (carrier_i),
		.symbol_error_i                  (symbol_error_i),
		.collision_i                     (collision_i),
		.controller_force_fast_link_i    (controller_force_fast_link_i),
		.host_status_transceiver_event_o (host_status_transceiver_event_o),
		.block_code_bypass_o             (block_code_bypass_o),
		.receive_clock_free_o            (receive_clock_free_o),
		.true_quiet_enable_o             (true_quiet_enable_o),
		.signal_detect_force_o           (signal_detect_force_o),
		.signal_detect_algorithm_o       (signal_detect_algorithm_o),
		.force_fast_link_o               (force_fast_link_o),
		.nrzi_bypass_o                   (nrzi_bypass_o)
	);
	task chk(input [63:0] nm, input [15:0] exp, input [15:0] got);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("mismatch %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task wreg(input [7:0] a, input [15:0] d);
		begin
			@(posedge clk_i) begin reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1; end
			@(posedge clk_i) reg_wr_i <= 1'b0;
		end
	endtask
	// the strobe is dropped for a cycle between accesses, so no signal is driven twice in one step
	task rreg(input [7:0] a, input [15:0] e);
		begin
			@(posedge clk_i) begin reg_addr_i <= a; reg_rd_i <= 1'b1; end
			@(posedge clk_i) reg_rd_i <= 1'b0;
			#1 chk("rdata", e, reg_rdata_o);
		end
	endtask
	task pulse(input [3:0] v);
		begin
			@(posedge clk_i) {autoneg_done_i, remote_fault_i, jabber_i, link_change_i} <= v;
			@(posedge clk_i) {autoneg_done_i, remote_fault_i, jabber_i, link_change_i} <= 4'h0;
		end
	endtask
	task fcn(input integer n);
		begin
			@(posedge clk_i) false_carrier_i <= 1'b1;
			repeat (n) @(posedge clk_i);
			false_carrier_i <= 1'b0;
		end
	endtask
	// errors last three cycles, collision only the first: a late veto would still count
	task frame(input e, input c);
		begin
			@(posedge clk_i) begin carrier_i <= 1'b1; symbol_error_i <= e; collision_i <= c; end
			@(posedge clk_i) collision_i <= 1'b0;
			repeat (2) @(posedge clk_i);
			{carrier_i, symbol_error_i} <= 2'b00;
			@(posedge clk_i);
		end
	endtask
	task t_reset;
		begin
			rreg(8'hC4, 16'h0000);
			rreg(8'hC8, 16'h0000);
			rreg(8'hD0, 16'h0000);
			rreg(8'hD4, 16'h0000);
			rreg(8'hD8, 16'h0100);
			rreg(8'hE0, 16'h0000);
			chk("cfg", 16'h0004, {9'h000, cfg});
			wreg(8'hC4, 16'hFFFF);
			rreg(8'hC4, 16'h0003);
			wreg(8'hC4, 16'h0000);
			rreg(8'hC8, 16'h8000);
		end
	endtask
	task t_events;
		begin
			wreg(8'hC4, 16'h0002);
			for (i = 0; i < 4; i = i + 1) begin
				wreg(8'hC8, 16'h4000 >> i);
				pulse(4'h1 << i);
				rreg(8'hC8, 16'h4000 >> i);
				wreg(8'hC8, 16'h7E00 ^ (16'h4000 >> i));
				pulse(4'h1 << i);
				@(posedge clk_i) #1 chk("host", 16'h0001, {15'h0000, host_status_transceiver_event_o});
				rreg(8'hC8, 16'h8000 | 16'h7E00 ^ (16'h4000 >> i));
				rreg(8'hC8, 16'h7E00 ^ (16'h4000 >> i));
			end
			wreg(8'hC4, 16'h0000);
			wreg(8'hC8, 16'h0000);
			pulse(4'hF);
			rreg(8'hC8, 16'h0000);
			wreg(8'hC4, 16'h0001);
			rreg(8'hE0, 16'h0000);
			rreg(8'hC8, 16'h8000);
			wreg(8'hC4, 16'h0000);
			rreg(8'hC8, 16'h8000);
			rreg(8'hC8, 16'h0000);
		end
	endtask
	task t_counters;
		begin
			fcn(3);
			rreg(8'hD0, 16'h0003);
			rreg(8'hD0, 16'h0000);
			wreg(8'hD0, 16'hFFFE);
			fcn(3);
			rreg(8'hD0, 16'h00FF);
			wreg(8'hC4, 16'h0002);
			wreg(8'hC8, 16'h7A00);
			wreg(8'hD0, 16'h007E);
			fcn(1);
			rreg(8'hC8, 16'h7A00);
			fcn(1);
			rreg(8'hC8, 16'hFA00);
			wreg(8'hC8, 16'h7C00);
			wreg(8'hD4, 16'h007F);
			frame(1'b1, 1'b0);
			rreg(8'hC8, 16'hFC00);
			wreg(8'hC4, 16'h0000);
			wreg(8'hD4, 16'h0000);
			frame(1'b1, 1'b0);
			frame(1'b0, 1'b0);
			frame(1'b1, 1'b1);
			rreg(8'hD4, 16'h0001);
			wreg(8'hD4, 16'h00FF);
			frame(1'b1, 1'b0);
			rreg(8'hD4, 16'h00FF);
		end
	endtask
	task t_cfg;
		begin
			wreg(8'hD8, 16'hFFFF);
			rreg(8'hD8, 16'h1F24);
			chk("cfg", 16'h007F, {9'h000, cfg});
			wreg(8'hD8, 16'h0000);
			rreg(8'hD8, 16'h0000);
			@(posedge clk_i) controller_force_fast_link_i <= 1'b1;
			repeat (2) @(posedge clk_i);
			#1 chk("cfg", 16'h0002, {9'h000, cfg});
		end
	endtask
	task conclude;
		begin
			$display("checks %0d miscompares %0d", checks, miscompares);
			if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
			else $display("CHECKS NOT OK");
			$finish;
		end
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_reset;
		t_events;
		t_counters;
		t_cfg;
		conclude;
	end
	// the sequence needs well under a thousand cycles
	initial begin
		#500000;
		miscompares = miscompares + 1;
		conclude;
	end
endmodule // pecc_tb_top
